/* hw/fssb_map.svh */
`ifndef FSSB_MAP_SVH
`define FSSB_MAP_SVH

// Command codes used on the status read port
`define FSSB_CMD_SUMMARY_LOW     8'h78
`define FSSB_CMD_SUMMARY_FULL    8'h79
`define FSSB_CMD_VOUT_FAULTS     8'h7A
`define FSSB_CMD_INPUT_FAULTS    8'h7C

// Summary word bit positions
`define FSSB_SW_VOUT             15
`define FSSB_SW_INPUT            13
`define FSSB_SW_MFR              12
`define FSSB_SW_PNG              11
`define FSSB_SW_BUSY             7
`define FSSB_SW_OFF              6
`define FSSB_SW_VOUT_OV          5
`define FSSB_SW_VIN_UV           3
`define FSSB_SW_TEMP             2
`define FSSB_SW_CML              1
`define FSSB_SW_HIGH             0

// Output-voltage fault bits
`define FSSB_VO_OV_FAULT         7
`define FSSB_VO_OV_WARN          6
`define FSSB_VO_UV_WARN          5
`define FSSB_VO_UV_FAULT         4
`define FSSB_VO_MAX_WARN         3
`define FSSB_VO_TON_MAX          2

// Input-voltage fault bits
`define FSSB_VI_OV_FAULT         7
`define FSSB_VI_OV_WARN          6
`define FSSB_VI_UV_WARN          5
`define FSSB_VI_UV_FAULT         4
`define FSSB_VI_OFF              3

// Implemented-bit masks; all other bits read zero
`define FSSB_VO_MASK             8'hFC
`define FSSB_VI_MASK             8'hF8

// Reset values
`define FSSB_RST_BYTE            8'h00
`define FSSB_RST_WORD            16'h0000

`endif

/* hw/fssb_pkg.sv */
package fssb_pkg;

  typedef struct packed {
    logic [1:0]  ctl_sync;      // Control pin synchroniser
    logic [1:0]  bias_sync;     // Input sense synchroniser
    logic        ctl_prev;      // Last synchronised control level
    logic        bias_prev;     // Last synchronised bias level
    logic        bias_lost;     // Bias was removed while latched
    logic        latched_off;   // Channel held off after a fault
    logic        chan_on;       // Channel delivering power
    logic        pg;            // Power good reflection
    logic [5:0]  vout_st;       // Sticky output-voltage bits 7..2
    logic [3:0]  vin_st;        // Sticky input-voltage bits 7..4
    logic        busy_st;
    logic        temp_st;
    logic        cml_st;
    logic        mfr_st;
    logic        alert;         // Alert pending
    logic        rd_ack;
    logic        rd_err;
    logic [15:0] rd_data;
  } fssb_state_t;

endpackage : fssb_pkg

/* hw/fssb_bank.sv */
`timescale 1ns/1ps
`include "fssb_map.svh"
// What this block does
// - A channel shut down by a fault stays latched off, no self restart.
// - Latch releases on control toggle, operation/on-off command, or bias removed and restored.
// - Every fault or warning pulls alert low and sets its status bits.
// - Clear-faults resets status and alert, but leaves the latched off state.
// - Summary byte equals the low byte of the summary word, one register.
// - Word bit 15 set on any output voltage fault or warning.
// - Word bit 13 set on any input voltage fault or warning.
// - Word bit 12 set on any manufacturer-specific fault.
// - Word bit 11 set when power-good is enabled and negated.
// - Unsupported status bits always read zero.
// - Word bit 7 set when a command arrives while busy.
// - Word bit 6 set whenever the channel delivers no output power.
// - Word bit 5 set on output overvoltage fault.
// - Word bit 3 set on input undervoltage fault.
// - Word bit 2 set on any temperature fault or warning.
// - Word bit 1 set on communication, memory or logic fault.
// - Word bit 0 set for faults outside bits 7..1 or power not good.
// - Output-voltage register bits 7..2: ov fault, ov warn, uv warn, uv fault, max, ton.
// - Input-voltage register bits 7..4: ov fault, ov warn, uv warn, uv fault.
// - Input-voltage bit 3 set while off for insufficient input voltage.

module fssb_bank
  import fssb_pkg::*;
(
  input  wire logic        clk,              // 10 MHz clock
  input  wire logic        resetn,           // Async reset, active low
  input  wire logic        control_pin,      // Channel control pin, asynchronous
  input  wire logic        input_sense_pin,  // Bias present on input sense, asynchronous
  input  wire logic        op_cmd,           // Operation or on/off config command pulse
  input  wire logic        clear_faults,     // Clear-faults command pulse
  input  wire logic        chan_enable,      // Channel commanded on
  input  wire logic        fault_shutdown,   // Fault response shuts channel down, pulse
  input  wire logic [5:0]  vout_evt,         // Output-voltage events, bits 7..2 order
  input  wire logic [3:0]  vin_evt,          // Input-voltage events, bits 7..4 order
  input  wire logic        vin_off,          // Off for insufficient input, level
  input  wire logic        busy_evt,         // Command received while busy, pulse
  input  wire logic        temp_evt,         // Temperature fault or warning, pulse
  input  wire logic        cml_evt,          // Comm/memory/logic fault, pulse
  input  wire logic        mfr_evt,          // Manufacturer-specific fault, pulse
  input  wire logic        pg_enable,        // Power-good output enabled
  input  wire logic        pg_level,         // Internal power-good level
  input  wire logic        rd_req,           // Status read request, pulse
  input  wire logic [7:0]  rd_cmd,           // Status command code
  output logic [15:0]      rd_data,          // Read data, low byte for byte reads
  output logic             rd_ack,           // Read answer, pulse
  output logic             rd_err,           // Unknown command, pulse with ack
  output logic             alert_out_n_o,    // Alert pin output value
  output logic             alert_out_n_oe,   // Alert pin drive enable
  output logic             power_good_out,   // Power-good pin
  output logic             chan_on,          // Channel delivering power
  output logic             latched_off       // Channel held off after fault
);

  //////////////////////////////////////////////////////////////////////////////
  fssb_state_t s_r;
  fssb_state_t s_nxt;

  logic        ctl_s;
  logic        bias_s;
  logic        any_evt;
  logic        release_latch;
  logic [7:0]  vout_reg;
  logic [7:0]  vin_reg;
  logic [15:0] word_reg;
  logic        png;

  //////////////////////////////////////////////////////////////////////////////
  // Read-side view of the status registers
  always_comb begin
    png      = pg_enable & ~s_r.pg;
    vout_reg = {s_r.vout_st, 2'b00} & `FSSB_VO_MASK;
    vin_reg  = {s_r.vin_st, vin_off, 3'b000} & `FSSB_VI_MASK;
    word_reg = `FSSB_RST_WORD;
    word_reg[`FSSB_SW_VOUT]    = |vout_reg;
    word_reg[`FSSB_SW_INPUT]   = |vin_reg;
    word_reg[`FSSB_SW_MFR]     = s_r.mfr_st;
    word_reg[`FSSB_SW_PNG]     = png;
    word_reg[`FSSB_SW_BUSY]    = s_r.busy_st;
    word_reg[`FSSB_SW_OFF]     = ~s_r.chan_on;
    word_reg[`FSSB_SW_VOUT_OV] = vout_reg[`FSSB_VO_OV_FAULT];
    word_reg[`FSSB_SW_VIN_UV]  = vin_reg[`FSSB_VI_UV_FAULT];
    word_reg[`FSSB_SW_TEMP]    = s_r.temp_st;
    word_reg[`FSSB_SW_CML]     = s_r.cml_st;
    word_reg[`FSSB_SW_HIGH]    = word_reg[`FSSB_SW_VOUT] | word_reg[`FSSB_SW_INPUT]
                               | word_reg[`FSSB_SW_MFR] | png;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt = s_r;

    s_nxt.ctl_sync  = {s_r.ctl_sync[0], control_pin};
    s_nxt.bias_sync = {s_r.bias_sync[0], input_sense_pin};
    ctl_s           = s_r.ctl_sync[1];
    bias_s          = s_r.bias_sync[1];
    s_nxt.ctl_prev  = ctl_s;
    s_nxt.bias_prev = bias_s;

    // Bias removal is remembered so that restoring it releases the latch
    if (s_r.latched_off && !bias_s) begin
      s_nxt.bias_lost = 1'b1;
    end else if (bias_s) begin
      s_nxt.bias_lost = 1'b0;
    end

    release_latch = (ctl_s != s_r.ctl_prev) | op_cmd
                  | (bias_s & ~s_r.bias_prev & s_r.bias_lost);

    // A new shutdown wins over a release in the same cycle
    if (fault_shutdown) begin
      s_nxt.latched_off = 1'b1;
    end else if (release_latch) begin
      s_nxt.latched_off = 1'b0;
    end

    // Clear-faults never touches the latch, so the channel stays off
    s_nxt.chan_on = chan_enable & bias_s & ~s_nxt.latched_off;
    s_nxt.pg      = pg_level & s_nxt.chan_on;

    // Sticky status: an event in the clearing cycle still sets its bit
    if (clear_faults) begin
      s_nxt.vout_st = 6'h00;
      s_nxt.vin_st  = 4'h0;
      s_nxt.busy_st = 1'b0;
      s_nxt.temp_st = 1'b0;
      s_nxt.cml_st  = 1'b0;
      s_nxt.mfr_st  = 1'b0;
      s_nxt.alert   = 1'b0;
    end
    s_nxt.vout_st = s_nxt.vout_st | vout_evt;
    s_nxt.vin_st  = s_nxt.vin_st | vin_evt;
    s_nxt.busy_st = s_nxt.busy_st | busy_evt;
    s_nxt.temp_st = s_nxt.temp_st | temp_evt;
    s_nxt.cml_st  = s_nxt.cml_st | cml_evt;
    s_nxt.mfr_st  = s_nxt.mfr_st | mfr_evt;

    any_evt     = (|vout_evt) | (|vin_evt) | busy_evt | temp_evt | cml_evt | mfr_evt;
    s_nxt.alert = s_nxt.alert | any_evt;

    // Status read port
    s_nxt.rd_ack  = rd_req;
    s_nxt.rd_err  = 1'b0;
    s_nxt.rd_data = `FSSB_RST_WORD;
    if (rd_req) begin
      case (rd_cmd)
        `FSSB_CMD_SUMMARY_LOW:  s_nxt.rd_data = {8'h00, word_reg[7:0]};
        `FSSB_CMD_SUMMARY_FULL: s_nxt.rd_data = word_reg;
        `FSSB_CMD_VOUT_FAULTS:  s_nxt.rd_data = {8'h00, vout_reg};
        `FSSB_CMD_INPUT_FAULTS: s_nxt.rd_data = {8'h00, vin_reg};
        default:                s_nxt.rd_err  = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data        = s_r.rd_data;
  assign rd_ack         = s_r.rd_ack;
  assign rd_err         = s_r.rd_err;
  assign alert_out_n_o  = 1'b0;
  assign alert_out_n_oe = s_r.alert;
  assign power_good_out = s_r.pg;
  assign chan_on        = s_r.chan_on;
  assign latched_off    = s_r.latched_off;

endmodule : fssb_bank

/* sim/fssb_host_model.sv */
`timescale 1ns/1ps
module fssb_host_model
  import fssb_pkg::*;
(
  input  wire logic        clk,     // Clock
  input  wire logic [15:0] rd_data, // Data
  input  wire logic        rd_ack,  // Answer
  input  wire logic        rd_err,  // Refused
  output logic             rd_req,  // Read
  output logic [7:0]       rd_cmd   // Code
);
  initial rd_req = 1'b0;
  initial rd_cmd = 8'h00;
  // Request stands for one edge; the answer stands for the following cycle only,
  // so it is taken at the next falling edge before the code lines change
  task automatic do_read(input logic [7:0] cmd, output logic [17:0] ans);
    @(negedge clk);
    rd_req = 1'b1;
    rd_cmd = cmd;
    @(negedge clk);
    ans    = {rd_ack, rd_err, rd_data};
    rd_req = 1'b0;
    rd_cmd = ~cmd;
  endtask : do_read
endmodule : fssb_host_model

/* sim/fssb_props.sv */
`timescale 1ns/1ps
`include "fssb_map.svh"
module fssb_props
  import fssb_pkg::*;
(
  input wire logic        clk,            // Clock
  input wire logic        resetn,         // Reset
  input wire logic        rd_req,         // Read
  input wire logic [7:0]  rd_cmd,         // Code
  input wire logic [15:0] rd_data,        // Data
  input wire logic        rd_ack,         // Answer
  input wire logic        rd_err,         // Refused
  input wire logic        clear_faults,   // Clear
  input wire logic        fault_shutdown, // Trip
  input wire logic [5:0]  vout_evt,       // Events
  input wire logic [3:0]  vin_evt,        // Events
  input wire logic        busy_evt,       // Event
  input wire logic        temp_evt,       // Event
  input wire logic        cml_evt,        // Event
  input wire logic        mfr_evt,        // Event
  input wire logic        alert_out_n_oe, // Alert drive
  input wire logic        chan_on,        // Power
  input wire logic        latched_off     // Latch
);
  wire logic any_evt = (|vout_evt) | (|vin_evt) | busy_evt | temp_evt | cml_evt | mfr_evt;
  wire logic known = rd_cmd inside {`FSSB_CMD_SUMMARY_LOW, `FSSB_CMD_SUMMARY_FULL,
                                    `FSSB_CMD_VOUT_FAULTS, `FSSB_CMD_INPUT_FAULTS};
  wire logic word = rd_cmd == `FSSB_CMD_SUMMARY_FULL;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_ack_next: assert property (rd_req |=> rd_ack) else $error("read not answered");
  chk_err_unknown: assert property (rd_req && !known |=> rd_err && rd_data == 16'h0000)
    else $error("unknown code not refused");
  chk_byte_high: assert property (rd_req && known && !word |=> !rd_err && rd_data[15:8] == 8'h00)
    else $error("byte read high bits set");
  chk_word_unused: assert property (rd_req && word |=> (rd_data & 16'h4710) == 16'h0000)
    else $error("unused word bit set");
  chk_off_bit: assert property (rd_req && word |=> rd_data[6] == !$past(chan_on))
    else $error("off bit wrong");
  chk_event_alert: assert property (any_evt |=> alert_out_n_oe) else $error("alert not driven");
  chk_clear_alert: assert property (clear_faults && !any_evt |=> !alert_out_n_oe)
    else $error("alert not released");
  chk_latch_set: assert property (fault_shutdown |=> latched_off && !chan_on) else $error("no latch");
  cov_refused: cover property (rd_ack && rd_err);
  cov_latched: cover property (fault_shutdown ##1 latched_off);
  cov_cleared: cover property (clear_faults && alert_out_n_oe);
endmodule : fssb_props
////////////////////////////////////////////////////////////////
bind fssb_bank fssb_props u_fssb_props (.clk, .resetn, .rd_req, .rd_cmd, .rd_data, .rd_ack, .rd_err,
  .clear_faults, .fault_shutdown, .vout_evt, .vin_evt, .busy_evt, .temp_evt, .cml_evt, .mfr_evt,
  .alert_out_n_oe, .chan_on, .latched_off);

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "fssb_map.svh"
module tb_top
  import fssb_pkg::*;
;
  localparam logic [7:0] cb = `FSSB_CMD_SUMMARY_LOW;
  localparam logic [7:0] cw = `FSSB_CMD_SUMMARY_FULL;
  localparam logic [7:0] co = `FSSB_CMD_VOUT_FAULTS;
  localparam logic [7:0] ci = `FSSB_CMD_INPUT_FAULTS;
  logic             clk, resetn, ctl, bias, en, pge, pgl, vin_off;
  logic [16:0]      ev;
  logic [15:0]      w;
  wire logic [15:0] rd_data;
  wire logic [7:0]  rd_cmd;
  wire logic        rd_req, rd_ack, rd_err, al_o, al_oe, pg_out, chan_on, latched;
  wire logic        alert_pin_n = al_oe ? al_o : 1'b1; // Pulled up when released
  int               err_total, compares;
  fssb_bank u_fssb_bank (.clk, .resetn, .control_pin(ctl), .input_sense_pin(bias), .op_cmd(ev[16]),
    .clear_faults(ev[14]), .chan_enable(en), .fault_shutdown(ev[15]), .vout_evt(ev[5:0]), .vin_evt(ev[9:6]),
    .vin_off, .busy_evt(ev[10]), .temp_evt(ev[11]), .cml_evt(ev[12]), .mfr_evt(ev[13]), .pg_enable(pge),
    .pg_level(pgl), .rd_req, .rd_cmd, .rd_data, .rd_ack, .rd_err, .alert_out_n_o(al_o),
    .alert_out_n_oe(al_oe), .power_good_out(pg_out), .chan_on, .latched_off(latched));
  fssb_host_model u_fssb_host_model (.clk, .rd_data, .rd_ack, .rd_err, .rd_req, .rd_cmd);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [17:0] exp, input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [16:0] exp);
    logic [17:0] r;
    u_fssb_host_model.do_read(c, r);
    chk($sformatf("read %h", c), {1'b1, exp}, r);
  endtask : rd
  task automatic strobe(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev = '0;
  endtask : strobe
  function automatic logic [15:0] wexp(input int k);
    if (k < 6) return 16'h8001 | (k == 5 ? 16'h0020 : 16'h0000);
    if (k < 10) return 16'h2001 | (k == 6 ? 16'h0008 : 16'h0000);
    return (k == 10) ? 16'h0080 : (k == 11) ? 16'h0004 : (k == 12) ? 16'h0002 : 16'h1001;
  endfunction : wexp
  task automatic print_verdict;
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 4000);
    err_total++;
    print_verdict();
  end
  initial begin
    {resetn, ctl, pge, vin_off} = 4'h0;
    {bias, en, pgl} = 3'h7;
    ev = '0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    rd(cw, 17'h0_0000);
    for (int k = 0; k < 14; k++) begin
      strobe(k);
      w = wexp(k);
      chk("alert pin", 18'h0_0000, alert_pin_n);
      rd(cw, {1'b0, w});
      rd(cb, {9'h000, w[7:0]});
      rd(co, k < 6 ? 17'h0_0004 << k : 17'h0_0000);
      rd(ci, (k > 5 && k < 10) ? 17'h0_0010 << (k - 6) : 17'h0_0000);
      strobe(14);
      chk("alert released", 18'h0_0001, alert_pin_n);
      rd(cw, 17'h0_0000);
    end
    vin_off = 1'b1;
    rd(ci, 17'h0_0008);
    vin_off = 1'b0;
    pge = 1'b1;
    pgl = 1'b0;
    repeat (2) @(negedge clk);
    chk("power good", 18'h0_0000, pg_out);
    rd(cw, 17'h0_0801);
    pge = 1'b0;
    pgl = 1'b1;
    rd(8'h00, 17'h1_0000);
    strobe(15);
    repeat (20) @(negedge clk);
    chk("latched", 18'h0_0001, {chan_on, latched});
    rd(cw, 17'h0_0040);
    strobe(14);
    chk("latch after clear", 18'h0_0001, {chan_on, latched});
    strobe(16);
    repeat (2) @(negedge clk);
    chk("released by command", 18'h0_0002, {chan_on, latched});
    strobe(15);
    ctl = ~ctl;
    repeat (5) @(negedge clk);
    chk("released by control", 18'h0_0002, {chan_on, latched});
    strobe(15);
    bias = 1'b0;
    repeat (5) @(negedge clk);
    chk("bias off", 18'h0_0001, {chan_on, latched});
    bias = 1'b1;
    repeat (5) @(negedge clk);
    chk("released by bias", 18'h0_0002, {chan_on, latched});
    print_verdict();
  end
endmodule : tb_top
